// *** common/tor_defines.svh ***
`ifndef TOR_DEFINES_SVH
`define TOR_DEFINES_SVH

// ------------------------------
// register byte offsets
// ------------------------------
`define TOR_OFF_CTRL    8'h00
`define TOR_OFF_THR     8'h04
`define TOR_OFF_OBJ     8'h08
`define TOR_OFF_LOAD    8'h0c
`define TOR_OFF_STATUS  8'h10
`define TOR_OFF_TEMP    8'h14
`define TOR_OFF_LEVEL   8'h18
`define TOR_OFF_CURRENT 8'h1c

// ------------------------------
// field positions and writable masks
// ------------------------------
`define TOR_CTRL_MASK   32'h0000_0003
`define TOR_THR_MASK    32'h00ff_ffff
`define TOR_OBJ_MASK    32'hffff_ffff
`define TOR_LOAD_MASK   32'h03ff_00ff
`define TOR_THR_ALARM   0
`define TOR_THR_TRIP    8
`define TOR_THR_UNLOCK  16
`define TOR_OBJ_RATED   0
`define TOR_OBJ_BASE    8
`define TOR_OBJ_AMBIENT 16
`define TOR_OBJ_STARTUP 24
`define TOR_LOAD_RATED  0
`define TOR_LOAD_TC     16

// ------------------------------
// reset values: pulsed mode, 80/100/60 deg, rated 100 deg, base 40 deg,
// ambient 25 deg, startup 0 %, rated load 100 %, time constant 10 min
// ------------------------------
`define TOR_CTRL_RST    32'h0000_0001
`define TOR_THR_RST     32'h003c_6450
`define TOR_OBJ_RST     32'h0019_2864
`define TOR_LOAD_RST    32'h000a_0064

// ------------------------------
// arithmetic and timing constants
// ------------------------------
`define TOR_STEP_US       20000
`define TOR_STEPS_PER_MIN (60000000 / `TOR_STEP_US)
`define TOR_CUR_PER_PCT   100
`define TOR_PCT_Q32       48'h0000_028f_5c29
`define TOR_TARGET_MAX    48'h0100_0000_0000
`define TOR_RESP_OKAY     2'b00
`define TOR_RESP_SLVERR   2'b10

`endif

// *** common/tor_pkg.sv ***
package tor_pkg;
    // operating mode, value 2'b11 behaves as off
    typedef enum logic [1:0] {
        TOR_MODE_OFF = 2'b00,
        TOR_MODE_PULSED = 2'b01,
        TOR_MODE_LOCKED = 2'b10
    } tor_mode_t;

    // replica update sequencer
    typedef enum logic [2:0] {
        TOR_ST_INIT = 3'b000,
        TOR_ST_IDLE = 3'b001,
        TOR_ST_TGT = 3'b010,
        TOR_ST_STEP = 3'b011,
        TOR_ST_EVAL = 3'b100
    } tor_state_t;
endpackage

// *** common/tor_div_if.sv ***
`timescale 1ns/1ps
`default_nettype none
// request and answer of the shared sequential divider
interface tor_div_if;
    logic start;
    logic [63:0] dividend;
    logic [31:0] divisor;
    logic done;
    logic [63:0] quotient;
    modport client (output start, output dividend, output divisor, input done, input quotient);
    modport server (input start, input dividend, input divisor, output done, output quotient);
endinterface
`default_nettype wire

// *** rtl/tor_divider.sv ***
`timescale 1ns/1ps
`default_nettype none
// restoring divider, one quotient bit per clock; a zero divisor gives all ones
module tor_divider (
    input wire logic aclk,
    input wire logic aresetn,
    tor_div_if.server div
);
    logic [32:0] rem_ff, nxt_rem;
    logic [63:0] quo_ff, nxt_quo;
    logic [31:0] dsr_ff, nxt_dsr;
    logic [6:0] cnt_ff, nxt_cnt;
    logic busy_ff, nxt_busy;
    logic done_ff, nxt_done;
    logic [32:0] rem_sh;

    // ------------------------------
    // shift and subtract
    // ------------------------------
    always_comb begin
        nxt_rem = rem_ff;
        nxt_quo = quo_ff;
        nxt_dsr = dsr_ff;
        nxt_cnt = cnt_ff;
        nxt_busy = busy_ff;
        nxt_done = 1'b0;
        rem_sh = {rem_ff[31:0], quo_ff[63]};
        if (div.start && !busy_ff) begin
            nxt_rem = 33'h0;
            nxt_quo = div.dividend;
            nxt_dsr = div.divisor;
            nxt_cnt = 7'h0;
            nxt_busy = 1'b1;
        end else if (busy_ff) begin
            if (rem_sh >= {1'b0, dsr_ff}) begin
                nxt_rem = rem_sh - {1'b0, dsr_ff};
                nxt_quo = {quo_ff[62:0], 1'b1};
            end else begin
                nxt_rem = rem_sh;
                nxt_quo = {quo_ff[62:0], 1'b0};
            end
            nxt_cnt = cnt_ff + 7'h1;
            if (cnt_ff == 7'h3f) begin
                nxt_busy = 1'b0;
                nxt_done = 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rem_ff <= 33'h0;
            quo_ff <= 64'h0;
            dsr_ff <= 32'h0;
            cnt_ff <= 7'h0;
            busy_ff <= 1'b0;
            done_ff <= 1'b0;
        end else begin
            rem_ff <= nxt_rem;
            quo_ff <= nxt_quo;
            dsr_ff <= nxt_dsr;
            cnt_ff <= nxt_cnt;
            busy_ff <= nxt_busy;
            done_ff <= nxt_done;
        end
    end

    assign div.done = done_ff;
    assign div.quotient = quo_ff;
endmodule
`default_nettype wire

// *** rtl/tor_top.sv ***
// Contract
// - form true-RMS of each phase current including harmonics up to the tenth
// - feed only the largest of the three phase values into the replica
// - temperature compared with limits is replica rise plus ambient
// - ambient temperature comes from a setting, default 25 degrees
// - thermal level approaches squared current ratio exponentially from its starting level
// - heating time constant set in whole minutes, default ten minutes
// - alarm whenever temperature exceeds alarm limit, default 80 degrees; the code raises no alarm in mode off
// - trip when temperature exceeds trip limit, default 100 degrees
// - mode selects off, pulsed or locked; pulsed gives a trip pulse
// - locked trip holds until temperature falls below unlock limit, default 60
// - after restart the replica starts at the startup level, default 0 %
// - reference current is rated load setting in percent, default 100 %
// - base temperature setting, default 40 degrees, defines allowed rise
// - three outputs: alarm, trip pulse, trip with restart inhibit
//
// Decided for this implementation: the register addresses and the AXI4-Lite interface to the registers.
`include "tor_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module tor_top #(
    parameter int WIN_LOG2 = 5
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic sample_valid,
    input wire logic signed [15:0] sample_l1,
    input wire logic signed [15:0] sample_l2,
    input wire logic signed [15:0] sample_l3,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic alarm,
    output logic trip_pulse,
    output logic trip_lock
);
    // ------------------------------
    // helpers
    // ------------------------------
    function automatic logic [31:0] square(input logic signed [15:0] s);
        logic signed [31:0] p;
        p = s * s;
        return p;
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] val, input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[b*8 +: 8] = val[b*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic [31:0] deg_q16(input logic [7:0] d);
        return {8'h0, d, 16'h0};
    endfunction

    // ------------------------------
    // register bus and settings
    // ------------------------------
    logic aw_full_ff, nxt_aw_full, w_full_ff, nxt_w_full;
    logic [7:0] awaddr_ff, nxt_awaddr;
    logic [31:0] wdata_ff, nxt_wdata;
    logic [3:0] wstrb_ff, nxt_wstrb;
    logic awready_ff, wready_ff, arready_ff;
    logic bvalid_ff, nxt_bvalid, rvalid_ff, nxt_rvalid;
    logic [1:0] bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
    logic [31:0] rdata_ff, nxt_rdata;
    logic [31:0] ctrl_ff, nxt_ctrl, thr_ff, nxt_thr, obj_ff, nxt_obj, load_ff, nxt_load;
    logic [47:0] level_ff;
    logic [31:0] temp_ff, ms_max_ff;
    logic alarm_ff, pulse_ff, lock_ff;

    // one write and one read may be in flight; address and data taken in either order
    always_comb begin
        nxt_aw_full = aw_full_ff;
        nxt_awaddr = awaddr_ff;
        nxt_w_full = w_full_ff;
        nxt_wdata = wdata_ff;
        nxt_wstrb = wstrb_ff;
        nxt_bvalid = bvalid_ff;
        nxt_bresp = bresp_ff;
        nxt_rvalid = rvalid_ff;
        nxt_rdata = rdata_ff;
        nxt_rresp = rresp_ff;
        nxt_ctrl = ctrl_ff;
        nxt_thr = thr_ff;
        nxt_obj = obj_ff;
        nxt_load = load_ff;
        if (s_axi_awvalid && awready_ff) begin
            nxt_aw_full = 1'b1;
            nxt_awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && wready_ff) begin
            nxt_w_full = 1'b1;
            nxt_wdata = s_axi_wdata;
            nxt_wstrb = s_axi_wstrb;
        end
        if (bvalid_ff && s_axi_bready) begin
            nxt_bvalid = 1'b0;
        end
        if (aw_full_ff && w_full_ff && !bvalid_ff) begin
            nxt_aw_full = 1'b0;
            nxt_w_full = 1'b0;
            nxt_bvalid = 1'b1;
            nxt_bresp = `TOR_RESP_OKAY;
            case (awaddr_ff)
                `TOR_OFF_CTRL: nxt_ctrl = merge(ctrl_ff, wdata_ff, wstrb_ff) & `TOR_CTRL_MASK;
                `TOR_OFF_THR: nxt_thr = merge(thr_ff, wdata_ff, wstrb_ff) & `TOR_THR_MASK;
                `TOR_OFF_OBJ: nxt_obj = merge(obj_ff, wdata_ff, wstrb_ff) & `TOR_OBJ_MASK;
                `TOR_OFF_LOAD: nxt_load = merge(load_ff, wdata_ff, wstrb_ff) & `TOR_LOAD_MASK;
                default: nxt_bresp = `TOR_RESP_SLVERR;
            endcase
        end
        if (rvalid_ff && s_axi_rready) begin
            nxt_rvalid = 1'b0;
        end
        if (s_axi_arvalid && arready_ff) begin
            nxt_rvalid = 1'b1;
            nxt_rresp = `TOR_RESP_OKAY;
            case (s_axi_araddr)
                `TOR_OFF_CTRL: nxt_rdata = ctrl_ff;
                `TOR_OFF_THR: nxt_rdata = thr_ff;
                `TOR_OFF_OBJ: nxt_rdata = obj_ff;
                `TOR_OFF_LOAD: nxt_rdata = load_ff;
                `TOR_OFF_STATUS: nxt_rdata = {29'h0, lock_ff, pulse_ff, alarm_ff};
                `TOR_OFF_TEMP: nxt_rdata = temp_ff;
                `TOR_OFF_LEVEL: nxt_rdata = level_ff[47:16];
                `TOR_OFF_CURRENT: nxt_rdata = ms_max_ff;
                default: begin
                    nxt_rdata = 32'h0;
                    nxt_rresp = `TOR_RESP_SLVERR;
                end
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_ff <= 1'b0;
            awaddr_ff <= 8'h0;
            w_full_ff <= 1'b0;
            wdata_ff <= 32'h0;
            wstrb_ff <= 4'h0;
            awready_ff <= 1'b0;
            wready_ff <= 1'b0;
            arready_ff <= 1'b0;
            bvalid_ff <= 1'b0;
            bresp_ff <= 2'b00;
            rvalid_ff <= 1'b0;
            rresp_ff <= 2'b00;
            rdata_ff <= 32'h0;
            ctrl_ff <= `TOR_CTRL_RST;
            thr_ff <= `TOR_THR_RST;
            obj_ff <= `TOR_OBJ_RST;
            load_ff <= `TOR_LOAD_RST;
        end else begin
            aw_full_ff <= nxt_aw_full;
            awaddr_ff <= nxt_awaddr;
            w_full_ff <= nxt_w_full;
            wdata_ff <= nxt_wdata;
            wstrb_ff <= nxt_wstrb;
            awready_ff <= !nxt_aw_full;
            wready_ff <= !nxt_w_full;
            arready_ff <= !nxt_rvalid;
            bvalid_ff <= nxt_bvalid;
            bresp_ff <= nxt_bresp;
            rvalid_ff <= nxt_rvalid;
            rresp_ff <= nxt_rresp;
            rdata_ff <= nxt_rdata;
            ctrl_ff <= nxt_ctrl;
            thr_ff <= nxt_thr;
            obj_ff <= nxt_obj;
            load_ff <= nxt_load;
        end
    end

    // ------------------------------
    // true-rms windows: mean square per phase, largest kept
    // ------------------------------
    logic [47:0] sum_ff [3], nxt_sum [3];
    logic [WIN_LOG2-1:0] cnt_ff, nxt_cnt;
    logic [31:0] nxt_ms_max;
    logic step_req_ff, nxt_step_req, step_take;
    logic [47:0] acc;
    logic [31:0] ms;

    // a window of 2**WIN_LOG2 samples per fundamental period resolves the 10th harmonic;
    // no square root is taken because the replica needs the squared current anyway
    always_comb begin
        nxt_cnt = cnt_ff;
        nxt_ms_max = ms_max_ff;
        nxt_step_req = step_req_ff;
        acc = 48'h0;
        ms = 32'h0;
        for (int p = 0; p < 3; p++) begin
            nxt_sum[p] = sum_ff[p];
        end
        if (step_take) begin
            nxt_step_req = 1'b0;
        end
        if (sample_valid) begin
            nxt_sum[0] = sum_ff[0] + {16'h0, square(sample_l1)};
            nxt_sum[1] = sum_ff[1] + {16'h0, square(sample_l2)};
            nxt_sum[2] = sum_ff[2] + {16'h0, square(sample_l3)};
            nxt_cnt = cnt_ff + 1'b1;
            if (&cnt_ff) begin
                nxt_ms_max = 32'h0;
                for (int p = 0; p < 3; p++) begin
                    acc = nxt_sum[p] >> WIN_LOG2;
                    ms = acc[31:0];
                    if (ms > nxt_ms_max) begin
                        nxt_ms_max = ms;
                    end
                    nxt_sum[p] = 48'h0;
                end
                nxt_step_req = 1'b1; // window end wins over a same-cycle take
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int p = 0; p < 3; p++) begin
                sum_ff[p] <= 48'h0;
            end
            cnt_ff <= '0;
            ms_max_ff <= 32'h0;
            step_req_ff <= 1'b0;
        end else begin
            for (int p = 0; p < 3; p++) begin
                sum_ff[p] <= nxt_sum[p];
            end
            cnt_ff <= nxt_cnt;
            ms_max_ff <= nxt_ms_max;
            step_req_ff <= nxt_step_req;
        end
    end

    // ------------------------------
    // thermal replica sequencer
    // ------------------------------
    tor_div_if div ();
    tor_divider u_div (
        .aclk(aclk),
        .aresetn(aresetn),
        .div(div)
    );

    tor_pkg::tor_state_t st_ff, nxt_st;
    tor_pkg::tor_mode_t mode;
    logic [47:0] nxt_level, target;
    logic [48:0] diff_ff, nxt_diff;
    logic [31:0] nxt_temp, in_ref, steps;
    logic [9:0] tc_min;
    logic [7:0] theta_n;
    logic [39:0] rise, temp_sum;
    logic over_prev_ff, nxt_over_prev, over_trip, nxt_alarm, nxt_pulse, nxt_lock;

    assign step_take = (st_ff == tor_pkg::TOR_ST_IDLE) && step_req_ff;

    // replica state plus trip logic; the divider is shared by the target and step divisions
    always_comb begin
        nxt_st = st_ff;
        nxt_level = level_ff;
        nxt_diff = diff_ff;
        nxt_temp = temp_ff;
        nxt_over_prev = over_prev_ff;
        nxt_alarm = alarm_ff;
        nxt_pulse = pulse_ff;
        nxt_lock = lock_ff;
        div.start = 1'b0;
        div.dividend = 64'h0;
        div.divisor = 32'h0;
        mode = tor_tor_mode(ctrl_ff[1:0]);
        in_ref = {16'h0, load_ff[`TOR_LOAD_RATED +: 8] * 16'(`TOR_CUR_PER_PCT)};
        tc_min = (load_ff[`TOR_LOAD_TC +: 10] == 10'h0) ? 10'h1 : load_ff[`TOR_LOAD_TC +: 10];
        steps = 32'(tc_min * 22'(`TOR_STEPS_PER_MIN));
        theta_n = (obj_ff[`TOR_OBJ_RATED +: 8] > obj_ff[`TOR_OBJ_BASE +: 8]) ?
            (obj_ff[`TOR_OBJ_RATED +: 8] - obj_ff[`TOR_OBJ_BASE +: 8]) : 8'h0;
        rise = level_ff[47:16] * theta_n;
        temp_sum = rise + {16'h0, obj_ff[`TOR_OBJ_AMBIENT +: 8], 16'h0};
        target = 48'h0;
        over_trip = 1'b0;
        case (st_ff)
            tor_pkg::TOR_ST_INIT: begin
                nxt_level = 48'(obj_ff[`TOR_OBJ_STARTUP +: 8] * `TOR_PCT_Q32);
                nxt_st = tor_pkg::TOR_ST_EVAL;
            end
            tor_pkg::TOR_ST_IDLE: begin
                if (step_req_ff) begin
                    div.start = 1'b1;
                    div.dividend = {ms_max_ff, 32'h0};
                    div.divisor = 32'(in_ref * in_ref); // squared reference current; the quotient is the squared current ratio
                    nxt_st = tor_pkg::TOR_ST_TGT;
                end
            end
            tor_pkg::TOR_ST_TGT: begin
                if (div.done) begin
                    target = (div.quotient > {16'h0, `TOR_TARGET_MAX}) ? `TOR_TARGET_MAX : div.quotient[47:0];
                    nxt_diff = {1'b0, target} - {1'b0, level_ff};
                    div.start = 1'b1;
                    div.dividend = {16'h0, nxt_diff[48] ? (48'h0 - nxt_diff[47:0]) : nxt_diff[47:0]};
                    div.divisor = steps;
                    nxt_st = tor_pkg::TOR_ST_STEP;
                end
            end
            tor_pkg::TOR_ST_STEP: begin
                if (div.done) begin
                    // first-order step: H += (target - H) * dt / T, rounding toward H
                    if (diff_ff[48]) begin
                        nxt_level = level_ff - div.quotient[47:0];
                    end else begin
                        nxt_level = level_ff + div.quotient[47:0];
                    end
                    nxt_st = tor_pkg::TOR_ST_EVAL;
                end
            end
            tor_pkg::TOR_ST_EVAL: begin
                nxt_temp = (|temp_sum[39:32]) ? 32'hffff_ffff : temp_sum[31:0];
                over_trip = nxt_temp > deg_q16(thr_ff[`TOR_THR_TRIP +: 8]);
                nxt_alarm = (mode != tor_pkg::TOR_MODE_OFF) &&
                    (nxt_temp > deg_q16(thr_ff[`TOR_THR_ALARM +: 8]));
                nxt_pulse = (mode == tor_pkg::TOR_MODE_PULSED) && over_trip && !over_prev_ff;
                if (mode != tor_pkg::TOR_MODE_LOCKED) begin
                    nxt_lock = 1'b0;
                end else if (over_trip) begin
                    nxt_lock = 1'b1;
                end else if (nxt_temp < deg_q16(thr_ff[`TOR_THR_UNLOCK +: 8])) begin
                    nxt_lock = 1'b0;
                end
                nxt_over_prev = over_trip;
                nxt_st = tor_pkg::TOR_ST_IDLE;
            end
            default: begin
                nxt_st = tor_pkg::TOR_ST_IDLE;
            end
        endcase
    end

    function automatic tor_pkg::tor_mode_t tor_tor_mode(input logic [1:0] m);
        case (m)
            2'b01: return tor_pkg::TOR_MODE_PULSED;
            2'b10: return tor_pkg::TOR_MODE_LOCKED;
            default: return tor_pkg::TOR_MODE_OFF;
        endcase
    endfunction

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_ff <= tor_pkg::TOR_ST_INIT;
            level_ff <= 48'h0;
            diff_ff <= 49'h0;
            temp_ff <= 32'h0;
            over_prev_ff <= 1'b0;
            alarm_ff <= 1'b0;
            pulse_ff <= 1'b0;
            lock_ff <= 1'b0;
        end else begin
            st_ff <= nxt_st;
            level_ff <= nxt_level;
            diff_ff <= nxt_diff;
            temp_ff <= nxt_temp;
            over_prev_ff <= nxt_over_prev;
            alarm_ff <= nxt_alarm;
            pulse_ff <= nxt_pulse;
            lock_ff <= nxt_lock;
        end
    end

    // every output straight from a flip-flop
    assign s_axi_awready = awready_ff;
    assign s_axi_wready = wready_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_arready = arready_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rresp = rresp_ff;
    assign s_axi_rdata = rdata_ff;
    assign alarm = alarm_ff;
    assign trip_pulse = pulse_ff;
    assign trip_lock = lock_ff;
endmodule
`default_nettype wire

// *** bench/tor_frontend_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ------------------------------
// phase current front end, steady samples
// ------------------------------
module tor_frontend_model #(
    parameter logic signed [15:0] AMP_L1 = 16'sh0000,
    parameter logic signed [15:0] AMP_L2 = 16'sh0000,
    parameter logic signed [15:0] AMP_L3 = 16'sh0000
) (
    input wire logic aclk,
    input wire logic aresetn,
    output logic sample_valid,
    output logic signed [15:0] sample_l1,
    output logic signed [15:0] sample_l2,
    output logic signed [15:0] sample_l3
);
    logic [2:0] div_ff;
    // one set every fifth cycle: a window must outlast the update pipeline
    always_ff @(posedge aclk) begin
        div_ff <= (!aresetn || div_ff == 3'h4) ? 3'h0 : div_ff + 3'h1;
    end
    // between sets the lines carry the inverse, never the held value
    always_comb begin
        sample_valid = (div_ff == 3'h4);
        sample_l1 = sample_valid ? AMP_L1 : ~AMP_L1;
        sample_l2 = sample_valid ? AMP_L2 : ~AMP_L2;
        sample_l3 = sample_valid ? AMP_L3 : ~AMP_L3;
    end
endmodule
`default_nettype wire

// *** bench/tor_top_props.sv ***
`timescale 1ns/1ps
`default_nettype none
// ------------------------------
// port checker
// ------------------------------
module tor_top_props (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic alarm,
    input wire logic trip_pulse,
    input wire logic trip_lock
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_wr_both; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready; endsequence
    sequence s_rd_take; s_axi_arvalid && s_axi_arready; endsequence
    property p_wr_answer; s_wr_both |=> !s_axi_bvalid ##1 s_axi_bvalid; endproperty
    property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
    property p_rd_answer; s_rd_take |=> s_axi_rvalid && !s_axi_arready; endproperty
    property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
    property p_reset_quiet; $rose(aresetn) |-> !alarm && !trip_pulse && !trip_lock; endproperty
    property p_pulse_len; $rose(trip_pulse) |=> trip_pulse[*8]; endproperty
    property p_lock_hold; $rose(trip_lock) |=> trip_lock[*8]; endproperty
    property p_mode_excl; !(trip_pulse && trip_lock); endproperty
    a_wr_answer: assert property (p_wr_answer) else $error("write response not two cycles on");
    a_b_hold: assert property (p_b_hold) else $error("write response dropped");
    a_rd_answer: assert property (p_rd_answer) else $error("read data not one cycle on");
    a_r_hold: assert property (p_r_hold) else $error("read data dropped or changed");
    a_reset_quiet: assert property (p_reset_quiet) else $error("output high after restart");
    a_pulse_len: assert property (p_pulse_len) else $error("trip pulse too short");
    a_lock_hold: assert property (p_lock_hold) else $error("trip lock too short");
    a_mode_excl: assert property (p_mode_excl) else $error("pulse and lock together");
endmodule
bind tor_top tor_top_props u_props (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rvalid, .s_axi_rready, .alarm, .trip_pulse, .trip_lock);
`default_nettype wire

// *** bench/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin err_count++; $display("unexpected %s exp %h got %h", n, e, g); end end
// ------------------------------
// register access and trip behaviour tests
// ------------------------------
module testbench;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic sample_valid;
    logic signed [15:0] sample_l1, sample_l2, sample_l3;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic alarm, trip_pulse, trip_lock;
    logic [31:0] rst_val [4] = '{32'h0000_0001, 32'h003c_6450, 32'h0019_2864, 32'h000a_0064};
    int err_count = 0, checks = 0, cycles = 0;
    always #5 aclk = ~aclk;
    // phase two is the largest, phase one negative to exercise squaring
    tor_frontend_model #(.AMP_L1(-16'sd200), .AMP_L2(16'sd300), .AMP_L3(16'sd100)) u_fe (.aclk, .aresetn,
        .sample_valid, .sample_l1, .sample_l2, .sample_l3);
    tor_top u_dut (.aclk, .aresetn, .sample_valid, .sample_l1, .sample_l2, .sample_l3, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .alarm, .trip_pulse, .trip_lock);
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // address and data offered together, each released when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s, output logic [1:0] rs);
        @(posedge aclk);
        {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, v, s};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
        do begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        rs = s_axi_bresp;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
        @(posedge aclk);
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'b11};
        do begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        {v, rs} = {s_axi_rdata, s_axi_rresp};
    endtask
    // a window plus the update pipeline is under 300 cycles
    task automatic settle();
        repeat (500) @(posedge aclk);
    endtask
    // a hang ends the run as a failure
    always @(posedge aclk) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            give_verdict();
        end
    end
    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            rd(8'(i * 4), d, r);
            `CHK("reset value", rst_val[i], d)
        end
        rd(8'h20, d, r);
        `CHK("unmapped read", 34'h2_0000_0000, {r, d})
        wr(8'h10, 32'h7, 4'hf, r);
        `CHK("read-only write", 2'b10, r)
        settle();
        rd(8'h14, d, r);
        `CHK("temperature", 16'd25, d[31:16])
        rd(8'h1c, d, r);
        `CHK("largest mean square", 32'd90000, d)
        $display("test registers done");
        wr(8'h04, 32'h0014_1418, 4'hf, r);
        for (int k = 0; k < 1000 && trip_pulse !== 1'b1; k++) @(posedge aclk);
        `CHK("trip pulse", 2'b11, {trip_pulse, alarm})
        settle();
        `CHK("single pulse", 3'b100, {alarm, trip_pulse, trip_lock})
        wr(8'h00, 32'h2, 4'hf, r);
        settle();
        `CHK("lock set", 1'b1, trip_lock)
        wr(8'h04, 32'h0014_c818, 4'hf, r);
        settle();
        `CHK("lock held", 1'b1, trip_lock)
        wr(8'h04, 32'h001e_c818, 4'hf, r);
        settle();
        `CHK("lock released", 1'b0, trip_lock)
        $display("test trip modes done");
        wr(8'h08, 32'h000a_0000, 4'b0100, r);
        settle();
        rd(8'h14, d, r);
        `CHK("cool ambient", 17'd10, {alarm, d[31:16]})
        wr(8'h00, 32'h0, 4'hf, r);
        wr(8'h08, 32'h0019_0000, 4'b0100, r);
        wr(8'h04, 32'h0014_1418, 4'hf, r);
        settle();
        `CHK("mode off", 3'b000, {alarm, trip_pulse, trip_lock})
        $display("test ambient and off done");
        give_verdict();
    end
endmodule
`default_nettype wire
